// File: rtl/tec_cfg.svh
// constants for the drive-side telegram failure counters
// assumes one pass/fail strobe per telegram type per communication cycle
// Functional notes
// R1: CP4 failed MDT bumps successive counter
// R2: valid MDT clears successive counter
// R3: successive count two: CP0, shutdown, error flag
// R4: master keeps per-drive AT counters; the master model keeps one atCount only
// R5: master skips third and later bad ATs
// R6: master zeroes AT counters entering CP3
// R7: master AT counting CP3/CP4, saturates
// R8: master exposes AT counts for reading
// R9: sync count in CP3/CP4, saturating
// R10: sync runs beyond two not counted
// R11: sync count readable, clearable from CP2
// R12: MDT count in CP4 only, saturating
// R13: MDT runs beyond two not counted
// R14: MDT count zeroed entering CP4
// R15: MDT count readable, clearable from CP2
// R16: inputs are per-cycle verdicts plus phase
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH
`define TEC_CNT_W      16
`define TEC_CNT_MAX    16'hFFFF
`define TEC_CNT_RST    16'h0000
`define TEC_RUN_LIMIT  2'h2
`define TEC_CP0        3'h0
`define TEC_CP2        3'h2
`define TEC_CP3        3'h3
`define TEC_CP4        3'h4
`endif

// File: rtl/tec_pkg.sv
// types shared by the telegram failure counter block
// assumes the phase code is a 3-bit number 0..4
`default_nettype none
package tec_pkg;
  typedef logic [2:0]  tec_phase_t;
  typedef logic [15:0] tec_count_t;
  typedef enum logic [1:0] {TEC_RUN, TEC_WAIT_CP0} tec_fall_t;
endpackage : tec_pkg
`default_nettype wire

// File: rtl/tec_cum_counter.sv
// saturating cumulative failure counter with run suppression
// assumes one verdict strobe per cycle and same-clock inputs
`include "tec_cfg.svh"
`default_nettype none
module tec_cum_counter
  import tec_pkg::*;
(
  input  wire  logic       clock,
  input  wire  logic       rst_n,
  input  wire  logic       tick,
  input  wire  logic       failed,
  input  wire  logic       countEn,
  input  wire  logic       zero,
  output var   tec_count_t count
);
  logic [1:0] runReg;
  // consecutive failures seen, stops at two
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      runReg <= 2'h0;
    end else if (tick) begin
      if (!failed) begin
        runReg <= 2'h0;
      end else if (runReg != `TEC_RUN_LIMIT) begin
        runReg <= runReg + 2'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count <= `TEC_CNT_RST;
    end else if (zero) begin
      count <= `TEC_CNT_RST;
    end else if (tick && failed && countEn && runReg != `TEC_RUN_LIMIT
                 && count != `TEC_CNT_MAX) begin
      count <= count + 16'h0001; // R10 R13
    end
  end
  sat_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (count == `TEC_CNT_MAX && !zero) |=> count == `TEC_CNT_MAX)
    else $error("count left saturation");
endmodule // tec_cum_counter
`default_nettype wire

// File: rtl/tec_phase_track.sv
// detects phase transitions from the phase code
// assumes the phase code is on the same clock
`include "tec_cfg.svh"
`default_nettype none
module tec_phase_track
  import tec_pkg::*;
(
  input  wire  logic       clock,
  input  wire  logic       rst_n,
  input  wire  tec_phase_t phase,
  output var   logic       enter3,
  output var   logic       enter4
);
  tec_phase_t prevReg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prevReg <= `TEC_CP0;
    end else begin
      prevReg <= phase;
    end
  end
  always_comb begin
    enter3 = (prevReg == `TEC_CP2) && (phase == `TEC_CP3);
    enter4 = (prevReg == `TEC_CP3) && (phase == `TEC_CP4);
  end
endmodule // tec_phase_track
`default_nettype wire

// File: rtl/tec_top.sv
// drive-side telegram failure counters: successive MDT and cumulative
// MST/MDT counters with phase gating and fallback request
// assumes verdict strobes come from same-clock telegram check logic
`include "tec_cfg.svh"
`default_nettype none
module tec_top
  import tec_pkg::*;
(
  input  wire  logic       clock,
  input  wire  logic       rst_n,
  input  wire  tec_phase_t phase,
  input  wire  logic       syncTick,
  input  wire  logic       syncFailed,
  input  wire  logic       dataTick,
  input  wire  logic       dataFailed,
  input  wire  logic       syncCountClear,
  input  wire  logic       dataCountClear,
  input  wire  logic       errorAck,
  output var   tec_count_t syncCount,
  output var   tec_count_t dataCount,
  output var   logic       fallbackCp0,
  output var   logic       shutdownDrives,
  output var   logic       commErrorFlag
);
  ////////////////////////////////////////////////////////////////////////
  logic       enter3;
  logic       enter4;
  logic [1:0] succReg;
  tec_fall_t  fall_reg;
  tec_count_t syncCnt;
  tec_count_t dataCnt;
  logic       inCp34;
  logic       inCp4;
  logic       fromCp2;
  logic       trip;
  logic       holdOff;
  // phase window decode, shared by the gates and the master clear window
  function automatic logic phase_in(input tec_phase_t ph,
                                    input tec_phase_t lo,
                                    input tec_phase_t hi);
    return (ph >= lo) && (ph <= hi);
  endfunction
  always_comb begin
    inCp34  = phase_in(phase, `TEC_CP3, `TEC_CP4);
    inCp4   = phase_in(phase, `TEC_CP4, `TEC_CP4);
    fromCp2 = phase_in(phase, `TEC_CP2, `TEC_CP4);
    // drives stay down from the trip until the master restarts in CP0
    holdOff = trip || (fall_reg == TEC_WAIT_CP0 && phase != `TEC_CP0);
  end
  tec_phase_track u_track (
    .clock  (clock),
    .rst_n  (rst_n),
    .phase  (phase),
    .enter3 (enter3),
    .enter4 (enter4)
  ); // R16
  ////////////////////////////////////////////////////////////////////////
  // successive MDT failures
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      succReg <= 2'h0;
    end else if (fall_reg == TEC_WAIT_CP0) begin
      succReg <= 2'h0;
    end else if (dataTick && !dataFailed) begin
      succReg <= 2'h0; // R2
    end else if (dataTick && inCp4 && succReg != `TEC_RUN_LIMIT) begin
      succReg <= succReg + 2'h1; // R1
    end
  end
  assign trip = (succReg == `TEC_RUN_LIMIT) && (fall_reg == TEC_RUN);
  // the flag is sticky until acknowledged; a new trip wins over the ack
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fall_reg <= TEC_RUN;
    end else begin
      case (fall_reg)
        TEC_RUN:      if (trip) fall_reg <= TEC_WAIT_CP0; // R3
        TEC_WAIT_CP0: if (phase == `TEC_CP0) fall_reg <= TEC_RUN;
        default:      fall_reg <= TEC_RUN;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fallbackCp0    <= 1'b0;
      shutdownDrives <= 1'b0;
    end else begin
      fallbackCp0    <= holdOff; // R3
      shutdownDrives <= holdOff; // R3
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      commErrorFlag <= 1'b0;
    end else if (trip) begin
      commErrorFlag <= 1'b1; // R3
    end else if (errorAck) begin
      commErrorFlag <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // cumulative counters; master clear honoured only from CP2 on
  tec_cum_counter u_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .tick    (syncTick),
    .failed  (syncFailed),
    .countEn (inCp34),                            // R9
    .zero    (enter3 || (syncCountClear && fromCp2)), // R9 R11
    .count   (syncCnt)
  );
  tec_cum_counter u_data (
    .clock   (clock),
    .rst_n   (rst_n),
    .tick    (dataTick),
    .failed  (dataFailed),
    .countEn (inCp4),                             // R12
    .zero    (enter4 || (dataCountClear && fromCp2)), // R14 R15
    .count   (dataCnt)
  );
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncCount <= `TEC_CNT_RST;
      dataCount <= `TEC_CNT_RST;
    end else begin
      syncCount <= syncCnt; // R11
      dataCount <= dataCnt; // R15
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence two_fails_s;
    (dataTick && dataFailed && inCp4 && fall_reg == TEC_RUN) [*2];
  endsequence
  two_fail_trip_a: assert property (@(posedge clock) disable iff (!rst_n)
    two_fails_s |=> succReg == 2'h2) // R3
    else $error("two failures did not reach the trip count");
  succ_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (dataTick && !dataFailed) |=> succReg == 2'h0) // R2
    else $error("successive counter not cleared");
  succ_inc_a: assert property (@(posedge clock) disable iff (!rst_n)
    (dataTick && dataFailed && inCp4 && succReg == 2'h0
     && fall_reg == TEC_RUN) |=> succReg == 2'h1) // R1
    else $error("successive counter not bumped");
  trip_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    (succReg == 2'h2 && fall_reg == TEC_RUN)
      |=> commErrorFlag && fallbackCp0 && shutdownDrives) // R3
    else $error("trip did not raise outputs");
  sync_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!inCp34 && !syncCountClear && !enter3) |=> $stable(syncCnt)) // R9
    else $error("sync count moved outside CP3/CP4");
  sync_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    enter3 |=> syncCnt == 16'h0000 ##1 syncCount == 16'h0000) // R9
    else $error("sync count not zeroed on CP3 entry");
  data_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!inCp4 && !dataCountClear && !enter4) |=> $stable(dataCnt)) // R12
    else $error("data count moved outside CP4");
  data_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    enter4 |=> dataCnt == 16'h0000) // R14
    else $error("data count not zeroed on CP4 entry");
  data_valid_a: assert property (@(posedge clock) disable iff (!rst_n)
    (dataTick && !dataFailed && !dataCountClear && !enter4)
      |=> $stable(dataCnt)) // R12
    else $error("data count moved on valid telegram");
  clear_early_a: assert property (@(posedge clock) disable iff (!rst_n)
    (dataCountClear && phase < `TEC_CP2 && !enter4)
      |=> $stable(dataCnt)) // R15
    else $error("clear honoured before CP2");
  out_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> syncCount == $past(syncCnt) && dataCount == $past(dataCnt))
    else $error("outputs do not follow counters");
  ////////////////////////////////////////////////////////////////////////
  // fallback and error flag behaviour after a trip, successive counter gating and range
  fall_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
    (fall_reg == TEC_WAIT_CP0 && phase != `TEC_CP0)
      |=> fallbackCp0 && shutdownDrives) // R3
    else $error("fallback dropped before CP0");
  fall_release_a: assert property (@(posedge clock) disable iff (!rst_n)
    (fall_reg == TEC_WAIT_CP0 && phase == `TEC_CP0)
      |=> !fallbackCp0 && fall_reg == TEC_RUN) // R3
    else $error("fallback not released in CP0");
  flag_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
    (commErrorFlag && !errorAck) |=> commErrorFlag) // R3
    else $error("error flag lost without ack");
  flag_ack_a: assert property (@(posedge clock) disable iff (!rst_n)
    (errorAck && !trip) |=> !commErrorFlag) // R3
    else $error("error flag not cleared by ack");
  succ_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (fall_reg == TEC_WAIT_CP0) |=> succReg == 2'h0) // R3
    else $error("successive counter ran while awaiting CP0");
  succ_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    (dataTick && dataFailed && !inCp4 && fall_reg == TEC_RUN)
      |=> $stable(succReg)) // R1
    else $error("successive counter moved outside CP4");
  succ_range_a: assert property (@(posedge clock) disable iff (!rst_n)
    succReg != 2'h3) // R3
    else $error("successive counter passed the trip count");
  ////////////////////////////////////////////////////////////////////////
  // cumulative counters: valid telegrams and master clears
  sync_valid_a: assert property (@(posedge clock) disable iff (!rst_n)
    (syncTick && !syncFailed && !syncCountClear && !enter3)
      |=> $stable(syncCnt)) // R9
    else $error("sync count moved on valid telegram");
  sync_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (syncCountClear && fromCp2) |=> syncCnt == 16'h0000) // R11
    else $error("sync count clear not honoured");
  data_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (dataCountClear && fromCp2) |=> dataCnt == 16'h0000) // R15
    else $error("data count clear not honoured");
endmodule // tec_top
`default_nettype wire

// File: tb/tec_master_model.sv
// master stand-in: one verdict per telegram type each cycle, own AT count
// assumes the bench sets phase and fail levels at the falling edge
`default_nettype none
module tec_master_model
  import tec_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire tec_phase_t phase,
  input  wire logic       failS,
  input  wire logic       failD,
  output var  logic       syncTick,
  output var  logic       syncFailed,
  output var  logic       dataTick,
  output var  logic       dataFailed,
  output var  tec_count_t atCount
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] atRun_reg;
  tec_phase_t lastPhase_reg;
  logic       atFail;
  assign syncTick = rst_n;
  assign dataTick = rst_n;
  assign syncFailed = failS;
  assign dataFailed = failD;
  always @(negedge clock) atFail <= ($urandom_range(3) == 0);
  // one drive only: the per-drive copies would be identical
  always_ff @(posedge clock) begin
    lastPhase_reg <= phase;
    atRun_reg <= !atFail ? 2'h0 : (atRun_reg == 2'h2) ? 2'h2 : atRun_reg + 2'h1;
    if (!rst_n) atCount <= 16'h0000;
    else if (phase == 3'h3 && lastPhase_reg == 3'h2) atCount <= 16'h0000;
    else if (atFail && atRun_reg < 2'h2 && phase >= 3'h3
             && atCount != 16'hFFFF) atCount <= atCount + 16'h0001;
  end
endmodule // tec_master_model
`default_nettype wire

// File: tb/test_telegram_error_counters.sv
// bench for the drive-side counters: random verdicts across phase steps
// assumes the master model feeds one verdict pair per cycle
`default_nettype none
module test_telegram_error_counters;
  import tec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock, rst_n, failS, failD, sClr, dClr, ack, chk;
  logic       sT, sF, dT, dF, fb, sd, ef, eFb, eEf, tr, fw;
  tec_phase_t phase, prevPh;
  tec_count_t sC, dC, eS, eD, pS, pD;
  logic [1:0] rS, rD, succ;
  int         miscompares, comparisons;
  tec_phase_t plan [12] = '{2, 3, 4, 0, 2, 3, 4, 1, 2, 3, 4, 0};
  tec_master_model mst (.clock(clock), .rst_n(rst_n), .phase(phase),
    .failS(failS), .failD(failD), .syncTick(sT), .syncFailed(sF),
    .dataTick(dT), .dataFailed(dF), .atCount());
  tec_top uut (.clock(clock), .rst_n(rst_n), .phase(phase), .syncTick(sT),
    .syncFailed(sF), .dataTick(dT), .dataFailed(dF), .syncCountClear(sClr),
    .dataCountClear(dClr), .errorAck(ack), .syncCount(sC), .dataCount(dC),
    .fallbackCp0(fb), .shutdownDrives(sd), .commErrorFlag(ef));
  ////////////////////////////////////////////////////////////////////////
  // outputs lag the internal state by one edge, hence the p* copies
  always @(posedge clock) begin
    pS = eS; pD = eD;
    if (!rst_n) begin
      eS = 0; eD = 0; eFb = 0; eEf = 0; rS = 0; rD = 0; succ = 0;
      tr = 0; fw = 0;
    end else begin
      if (phase == 3'h3 && prevPh == 3'h2) eS = 16'h0000;
      else if (sClr && phase >= 3'h2) eS = 16'h0000;
      else if (failS && rS < 2 && phase >= 3'h3 && eS != 16'hFFFF) eS++;
      if (phase == 3'h4 && prevPh == 3'h3) eD = 16'h0000;
      else if (dClr && phase >= 3'h2) eD = 16'h0000;
      else if (failD && rD < 2 && phase == 3'h4 && eD != 16'hFFFF) eD++;
      rS = !failS ? 0 : (rS == 2) ? 2 : rS + 1;
      rD = !failD ? 0 : (rD == 2) ? 2 : rD + 1;
      // flag and fallback are registered from this edge's inputs
      tr = (succ == 2) && !fw;
      eFb = tr || (fw && phase != 3'h0);
      eEf = tr || (eEf && !ack);
      if (fw) succ = 0;
      else if (!failD) succ = 0;
      else if (phase == 3'h4 && succ != 2) succ++;
      if (tr) fw = 1;
      else if (phase == 3'h0) fw = 0;
    end
    prevPh = phase;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check16(input string what, input tec_count_t exp,
                         input tec_count_t got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic check1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s exp %b got %b", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  initial begin
    #(100000 * 40);
    miscompares++;
    close_out;
  end
  initial begin
    rst_n = 0; phase = 0; failS = 0; failD = 0; sClr = 0; dClr = 0;
    ack = 0; chk = 0; miscompares = 0; comparisons = 0; prevPh = 0;
    void'($urandom(99));
    repeat (12) @(negedge clock);
    rst_n = 1;
    foreach (plan[i]) begin
      // quiet cycles from each phase step on keep zeroing apart from counting
      failS = 0; failD = 0; sClr = 0; dClr = 0; ack = 0; phase = plan[i];
      repeat (4) @(negedge clock);
      repeat (300) begin
        check16("syncCount", pS, sC);
        check16("dataCount", pD, dC);
        check1("fallbackCp0", eFb, fb);
        check1("shutdownDrives", eFb, sd);
        check1("commErrorFlag", eEf, ef);
        failS = ($urandom_range(3) == 0);
        failD = ($urandom_range(3) == 0);
        sClr = ($urandom_range(31) == 0);
        dClr = ($urandom_range(31) == 0);
        ack = ($urandom_range(15) == 0);
        if (sClr) failS = 0;
        if (dClr) failD = 0;
        @(negedge clock);
      end
    end
    close_out;
  end
endmodule // test_telegram_error_counters
`default_nettype wire
